// ### pkg/step_pkg.sv
// Constants and types shared by the single-step control block.
// Assumes a core that reports fetch boundaries and a 10 MHz clock.
package step_pkg;

  // Address and port widths
  localparam int ADDR_W = 10;
  localparam int PORT1_W = 8;
  localparam int PORT2_LO_W = 2;
  localparam int IRQ_W = 2;

  // Interrupt source positions
  localparam int IRQ_HOST_BIT = 0;
  localparam int IRQ_TIMER_BIT = 1;

  // Last count of instructions per timer increment; value is a plain default
  localparam int PRESCALE_W = 5;
  localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = 5'h1f;
  localparam logic [PRESCALE_W-1:0] PRESCALE_RST = 5'h00;

  // Reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 10'h000;
  localparam logic [PORT1_W-1:0] PORT1_RST = 8'hff;
  localparam logic [PORT2_LO_W-1:0] PORT2_LO_RST = 2'h3;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

  // Step request level after reset and while the pin is idle
  localparam logic REQ_IDLE = 1'b1;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_HALT,
    ST_STEP
  } step_state_t;

endpackage

// ### pkg/prescale_if.sv
// Link between the step controller and the timer prescaler.
// Assumes both ends share clock_in.
`timescale 1ns/1ns
interface prescale_if;
  logic count_en;
  logic tick;

  modport ctrl (
    output count_en,
    input tick
  );

  modport counter (
    input count_en,
    output tick
  );
endinterface

// ### src/instr_prescaler.sv
// Timer prescaler that counts enabled cycles and pulses a tick.
// Assumes count_en is a one-cycle qualifier on clock_in.
`timescale 1ns/1ns
module instr_prescaler (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  prescale_if.counter pre
);

  logic [step_pkg::PRESCALE_W-1:0] count_r;
  logic tick_r;

  // Count and wrap
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count_r <= step_pkg::PRESCALE_RST;
    end else if (clk_en_in && pre.count_en) begin
      if (count_r == step_pkg::PRESCALE_LAST) begin
        count_r <= step_pkg::PRESCALE_RST;
      end else begin
        count_r <= count_r + 1'b1;
      end
    end
  end

  // Tick on wrap
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tick_r <= 1'b0;
    end else if (clk_en_in) begin
      tick_r <= pre.count_en && (count_r == step_pkg::PRESCALE_LAST);
    end
  end

  assign pre.tick = tick_r;

endmodule

// ### src/single_step_debug_control.sv
// Single-instruction stepping control with port address display.
// Assumes the core pulses fetch_next_in one cycle before each fetch,
// obeys core_hold_out on that fetch, and shares clock_in.
// Port pins show the halted address one cycle after acknowledge rises.
`timescale 1ns/1ns
module single_step_debug_control (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  input wire logic step_req_b_in,
  input wire logic fetch_next_in,
  input wire logic [step_pkg::ADDR_W-1:0] next_addr_in,
  input wire logic [step_pkg::PORT1_W-1:0] port1_data_in,
  input wire logic [step_pkg::PORT2_LO_W-1:0] port2_lo_data_in,
  input wire logic host_in_buffer_full_in,
  input wire logic timer_irq_in,
  input wire logic [step_pkg::IRQ_W-1:0] irq_taken_in,
  output logic step_ack_out,
  output logic core_hold_out,
  output logic [step_pkg::PORT1_W-1:0] port1_out,
  output logic [step_pkg::PORT2_LO_W-1:0] port2_lo_out,
  output logic [step_pkg::IRQ_W-1:0] irq_pend_out,
  output logic timer_inc_out
);

  step_pkg::step_state_t state_r;
  step_pkg::step_state_t state_nxt;
  logic req_meta_r;
  logic req_sync_r;
  logic ack_r;
  logic hold_r;
  logic [step_pkg::ADDR_W-1:0] addr_r;
  logic [step_pkg::PORT1_W-1:0] port1_r;
  logic [step_pkg::PORT2_LO_W-1:0] port2_lo_r;
  logic [step_pkg::IRQ_W-1:0] irq_pend_r;
  logic [step_pkg::IRQ_W-1:0] irq_set;
  logic timer_inc_r;
  logic show_addr;
  logic keep_port;

  prescale_if pre_link ();

  // Pin synchroniser for the step request
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      req_meta_r <= step_pkg::REQ_IDLE;
      req_sync_r <= step_pkg::REQ_IDLE;
    end else if (clk_en_in) begin
      req_meta_r <= step_req_b_in;
      req_sync_r <= req_meta_r;
    end
  end

  // Next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      step_pkg::ST_RUN: begin
        if (fetch_next_in && !req_sync_r) begin
          state_nxt = step_pkg::ST_HALT;
        end
      end
      step_pkg::ST_HALT: begin
        if (req_sync_r) begin
          state_nxt = step_pkg::ST_STEP;
        end else begin
          state_nxt = step_pkg::ST_HALT;
        end
      end
      step_pkg::ST_STEP: begin
        if (fetch_next_in) begin
          if (req_sync_r) begin
            state_nxt = step_pkg::ST_RUN;
          end else begin
            state_nxt = step_pkg::ST_HALT;
          end
        end
      end
      default: begin
        state_nxt = step_pkg::ST_RUN;
      end
    endcase
  end

  // State register
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r <= step_pkg::ST_RUN;
    end else if (clk_en_in) begin
      state_r <= state_nxt;
    end
  end

  // Acknowledge follows the halted state
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_r <= 1'b0;
    end else if (clk_en_in) begin
      ack_r <= (state_nxt == step_pkg::ST_HALT);
    end
  end

  // Hold makes the core issue no-op cycles instead of fetching
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hold_r <= 1'b0;
    end else if (clk_en_in) begin
      hold_r <= (state_nxt == step_pkg::ST_HALT);
    end
  end

  // Capture the address of the instruction about to be fetched
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      addr_r <= step_pkg::ADDR_RST;
    end else if (clk_en_in && fetch_next_in) begin
      addr_r <= next_addr_in;
    end
  end

  // Address shown from the second halted cycle on
  assign show_addr = (state_r == step_pkg::ST_HALT) &&
    (state_nxt == step_pkg::ST_HALT);
  // Ports hold on the acknowledge rise, the address follows a cycle later
  assign keep_port = (state_r != step_pkg::ST_HALT) &&
    (state_nxt == step_pkg::ST_HALT);

  // Port 1: address low byte while halted, normal data otherwise
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      port1_r <= step_pkg::PORT1_RST;
    end else if (clk_en_in) begin
      if (show_addr) begin
        port1_r <= addr_r[step_pkg::PORT1_W-1:0];
      end else if (!keep_port) begin
        port1_r <= port1_data_in;
      end
    end
  end

  // Port 2 low pins: address high bits while halted, data otherwise
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      port2_lo_r <= step_pkg::PORT2_LO_RST;
    end else if (clk_en_in) begin
      if (show_addr) begin
        port2_lo_r <= addr_r[step_pkg::ADDR_W-1:step_pkg::PORT1_W];
      end else if (!keep_port) begin
        port2_lo_r <= port2_lo_data_in;
      end
    end
  end

  // Interrupt requests stay pending through halts; set wins over take
  assign irq_set[step_pkg::IRQ_HOST_BIT] = host_in_buffer_full_in;
  assign irq_set[step_pkg::IRQ_TIMER_BIT] = timer_irq_in | pre_link.tick;

  // One pending flag per interrupt source
  genvar gi;
  generate
    for (gi = 0; gi < step_pkg::IRQ_W; gi = gi + 1) begin : g_irq
      always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          irq_pend_r[gi] <= step_pkg::IRQ_RST[gi];
        end else if (clk_en_in) begin
          if (irq_set[gi]) begin
            irq_pend_r[gi] <= 1'b1;
          end else if (irq_taken_in[gi]) begin
            irq_pend_r[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Timer prescaler counts instructions, not cycles, and none while hold is high
  always_comb begin
    pre_link.count_en = fetch_next_in && !hold_r;
  end

  // Prescaler shares the clock enable, so a freeze stops it too
  instr_prescaler u_prescaler (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .clk_en_in(clk_en_in),
    .pre(pre_link.counter)
  );

  // Timer increment pulse to the core timer
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      timer_inc_r <= 1'b0;
    end else if (clk_en_in) begin
      timer_inc_r <= pre_link.tick;
    end
  end

  assign step_ack_out = ack_r;
  assign core_hold_out = hold_r;
  assign port1_out = port1_r;
  assign port2_lo_out = port2_lo_r;
  assign irq_pend_out = irq_pend_r;
  assign timer_inc_out = timer_inc_r;

endmodule

// ### test/step_sva.sv
// Port checker for the single-step control block.
// Bound to the top module; clock enable is held high.
`timescale 1ns/1ns
module step_sva (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic step_req_b_in,
  input wire logic fetch_next_in,
  input wire logic [step_pkg::ADDR_W-1:0] next_addr_in,
  input wire logic [step_pkg::PORT1_W-1:0] port1_data_in,
  input wire logic host_in_buffer_full_in,
  input wire logic step_ack_out,
  input wire logic core_hold_out,
  input wire logic [step_pkg::PORT1_W-1:0] port1_out,
  input wire logic [step_pkg::PORT2_LO_W-1:0] port2_lo_out,
  input wire logic [step_pkg::IRQ_W-1:0] irq_pend_out
);
  logic q1_r;
  logic q2_r;
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q1_r <= 1'b1;
      q2_r <= 1'b1;
    end else begin
      q1_r <= step_req_b_in;
      q2_r <= q1_r;
    end
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_entry;
    !q2_r && fetch_next_in;
  endsequence
  property p_halt;
    s_entry |=> step_ack_out && core_hold_out;
  endproperty
  a_halt: assert property (p_halt) else $error("no halt");
  sequence s_shown;
    s_entry ##1 !q2_r;
  endsequence
  property p_addr;
    s_shown |=> {port2_lo_out, port1_out} == $past(next_addr_in, 2);
  endproperty
  a_addr: assert property (p_addr) else $error("bad address");
  property p_keep;
    s_entry |=> $stable({port2_lo_out, port1_out});
  endproperty
  a_keep: assert property (p_keep) else $error("port moved");
  property p_stay;
    step_ack_out && !q2_r |=> step_ack_out;
  endproperty
  a_stay: assert property (p_stay) else $error("halt lost");
  property p_go;
    step_ack_out && q2_r |=> !step_ack_out && !core_hold_out;
  endproperty
  a_go: assert property (p_go) else $error("no release");
  property p_nop;
    core_hold_out == step_ack_out;
  endproperty
  a_nop: assert property (p_nop) else $error("hold mismatch");
  property p_run;
    q2_r && !step_ack_out |=> !step_ack_out;
  endproperty
  a_run: assert property (p_run) else $error("halt in run");
  property p_data;
    !step_ack_out && $past(rst_b_in) |-> port1_out == $past(port1_data_in);
  endproperty
  a_data: assert property (p_data) else $error("bad port data");
  property p_irq;
    host_in_buffer_full_in |=> irq_pend_out[0];
  endproperty
  a_irq: assert property (p_irq) else $error("host irq lost");
endmodule
bind single_step_debug_control step_sva i_step_sva (.*);

// ### test/step_ctrl.sv
// External step controller: run switch, step button, request latch.
// Assumes ack is the block's step acknowledge output.
`timescale 1ns/1ns
module step_ctrl (
  input wire logic ack_in,
  input wire logic run_in,
  input wire logic press_in,
  input wire logic [step_pkg::ADDR_W-1:0] port_in,
  output logic req_b_out,
  output logic [step_pkg::ADDR_W-1:0] latch_out,
  output logic drive_en_out
);
  initial req_b_out = 1'b0;
  always @(negedge ack_in or posedge run_in or posedge press_in) begin
    req_b_out <= run_in || press_in;
  end
  // Port latch keeps the last normal data on the acknowledge rise
  always @(posedge ack_in) begin
    latch_out <= port_in;
  end
  // Input drivers enabled only while acknowledge is low
  assign drive_en_out = !ack_in;
endmodule

// ### test/tb.sv
// Self-checking bench for the single-step control block.
// Assumes the step controller model and the bound checker.
`timescale 1ns/1ns
module tb;
  logic clock_in, rst_b_in, step_req_b_in, fetch_next_in, run, press;
  logic host_in_buffer_full_in, timer_irq_in, step_ack_out, core_hold_out;
  logic timer_inc_out, ack_q, ack_q2, pm, pt, tk, ti, drv;
  logic [step_pkg::ADDR_W-1:0] po, pd, pv, latch;
  logic [step_pkg::ADDR_W-1:0] next_addr_in;
  logic [step_pkg::PORT1_W-1:0] port1_data_in, port1_out;
  logic [step_pkg::PORT2_LO_W-1:0] port2_lo_data_in, port2_lo_out;
  logic [step_pkg::IRQ_W-1:0] irq_taken_in, irq_pend_out;
  logic [31:0] seed;
  int fails, samples_checked, c, tc;
  assign po = {port2_lo_out, port1_out};
  assign pd = {port2_lo_data_in, port1_data_in};
  single_step_debug_control i_single_step_debug_control (.clk_en_in(1'b1), .*);
  step_ctrl i_step_ctrl (.ack_in(step_ack_out), .run_in(run),
    .press_in(press), .port_in(po), .req_b_out(step_req_b_in),
    .latch_out(latch), .drive_en_out(drv));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  task automatic check(input string n, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_ack(input logic v);
    int i;
    for (i = 0; i < 200 && step_ack_out !== v; i++) @(negedge clock_in);
    if (step_ack_out !== v) begin
      fails++;
      summarize;
    end
  endtask
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  // Core model, port data, interrupts and result model
  always @(negedge clock_in) begin
    if (rst_b_in) begin
      if (step_ack_out && !ack_q) begin
        check("port_keep", po, pv);
        check("port_latch", latch, pv);
      end
      if (step_ack_out && ack_q && !ack_q2)
        check("halt_addr", po, next_addr_in);
      if (drv) check("port_data", po, pd);
      check("host_pend", irq_pend_out[0], pm);
      check("timer_pend", irq_pend_out[1], pt);
      check("timer_inc", timer_inc_out, ti);
    end else begin
      {pm, pt, tk} = 3'h0;
      tc = 0;
    end
    ack_q2 = ack_q;
    ack_q = step_ack_out;
    pv = po;
    ti = tk;
    c = core_hold_out ? 0 : c + 1;
    fetch_next_in = (c % 6 == 5);
    if (fetch_next_in) next_addr_in = next_addr_in + 10'h001;
    tk = fetch_next_in && tc == step_pkg::PRESCALE_LAST;
    if (fetch_next_in) tc = tk ? 0 : tc + 1;
    seed = xs(seed);
    {port2_lo_data_in, port1_data_in} = seed[9:0];
    host_in_buffer_full_in = seed[12:10] == 3'h0;
    timer_irq_in = seed[15:13] == 3'h0;
    irq_taken_in = seed[17:16];
    pm = (pm & !irq_taken_in[0]) | host_in_buffer_full_in;
    pt = (pt & !irq_taken_in[1]) | timer_irq_in | ti;
  end
  initial begin
    seed = 32'h3245;
    {rst_b_in, run, press, fetch_next_in, ack_q, pm} = 6'h00;
    {host_in_buffer_full_in, timer_irq_in, irq_taken_in} = 4'h0;
    {next_addr_in, port1_data_in, port2_lo_data_in} = 20'h00000;
    {fails, samples_checked, c} = {32'h0, 32'h0, 32'h0};
    {ack_q2, pt, tk, ti} = 4'h0;
    tc = 0;
    pv = 10'h000;
    repeat (8) @(posedge clock_in);
    @(negedge clock_in) rst_b_in <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      wait_ack(1'b1);
      repeat (20) @(negedge clock_in);
      check("halt_stays", step_ack_out, 1'b1);
      press <= 1'b1;
      @(negedge clock_in) press <= 1'b0;
      wait_ack(1'b0);
    end
    run <= 1'b1;
    repeat (300) @(negedge clock_in) check("run", step_ack_out, 1'b0);
    summarize;
  end
endmodule
